// *** rtl/svm_pkg.sv ***
// Purpose : Shared constants and state types of the supply monitor control
// Assumes : 10 MHz core clock, Avalon-MM register port with byte addresses
// Notes   : Register indices are kept as printed; byte address is index * 4
package svm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] DETECT_FLAGS_LEVELS_IDX = 12'hfc6;
  localparam logic [11:0] DETECT_MODE_ENABLE_IDX  = 12'hfc7;
  localparam int          ADDR_W                  = 14;
  localparam logic [13:0] DETECT_FLAGS_LEVELS_ADR = {DETECT_FLAGS_LEVELS_IDX, 2'b00};
  localparam logic [13:0] DETECT_MODE_ENABLE_ADR  = {DETECT_MODE_ENABLE_IDX, 2'b00};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CH2_FLAG_BIT = 7;
  localparam int CH2_LIVE_BIT = 6;
  localparam int CH2_LVL_LSB  = 4;
  localparam int CH1_FLAG_BIT = 3;
  localparam int CH1_LIVE_BIT = 2;
  localparam int CH1_LVL_LSB  = 0;
  localparam int SPARE_LSB    = 4;
  localparam int CH2_MODE_BIT = 3;
  localparam int CH2_EN_BIT   = 2;
  localparam int CH1_MODE_BIT = 1;
  localparam int CH1_EN_BIT   = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CH1_LVL_RST = 2'h0;
  localparam logic [1:0] CH2_LVL_RST = 2'h2;
  localparam logic       RESP_IRQ    = 1'b0;
  localparam logic       RESP_RESET  = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ        = 10000;
  localparam int WARMUP_US      = 1000;
  localparam int WARMUP_CYCLES  = (WARMUP_US * CLK_KHZ) / 1000;
  localparam int WARM_CNT_W     = 16;
  localparam int SYNC_W         = 4;

  // ----------------------------------------------------------------
  // State carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] lvl1;
    logic [1:0] lvl2;
    logic [1:0] spare;
    logic [1:0] mode;
    logic [1:0] en;
    logic [1:0] flag;
    logic [1:0] below;
    logic [1:0] below_prev;
    logic [1:0] en_prev;
    logic       lvr;
    logic       irq;
    logic [7:0] rdata;
    logic       wait_req;
  } svm_state_t;

  localparam svm_state_t STATE_RST = '{lvl1: CH1_LVL_RST, lvl2: CH2_LVL_RST,
                                       wait_req: 1'b1, default: '0};

  typedef struct packed {
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
  } svm_sync_t;

  typedef struct packed {
    logic [WARM_CNT_W-1:0] cnt;
    logic                  hold;
  } svm_warm_t;

endpackage : svm_pkg

// *** rtl/svm_sync.sv ***
// Purpose : Two-stage synchroniser for asynchronous level inputs
// Assumes : Inputs are slow levels; no pulse narrower than a clock is expected
// Notes   : First stage feeds only the second stage
module svm_sync (
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_in,
  input  wire logic [svm_pkg::SYNC_W-1:0] async_in,
  output logic      [svm_pkg::SYNC_W-1:0] sync_out
);

  svm_pkg::svm_sync_t state_ff;
  svm_pkg::svm_sync_t nxt_state;

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  for (genvar i = 0; i < svm_pkg::SYNC_W; i++) begin : g_bit
    always_comb begin
      nxt_state.stage1[i] = async_in[i];
      nxt_state.stage2[i] = state_ff.stage1[i];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.stage2;

endmodule : svm_sync

// *** rtl/svm_warmup.sv ***
// Purpose : Warm-up counter holding the core in reset after a reset source
// Assumes : hold_in is already in the core clock domain
// Notes   : Any new hold restarts the full warm-up period
module svm_warmup #(
  parameter int WARMUP_CYCLES = svm_pkg::WARMUP_CYCLES
) (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic hold_in,
  output logic      cpu_rst_out
);

  svm_pkg::svm_warm_t state_ff;
  svm_pkg::svm_warm_t nxt_state;

  localparam logic [svm_pkg::WARM_CNT_W-1:0] LAST =
    svm_pkg::WARM_CNT_W'(WARMUP_CYCLES - 1);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    if (hold_in) begin
      nxt_state.cnt  = '0;                           // see [R14]
      nxt_state.hold = 1'b1;
    end else if (state_ff.hold) begin
      if (state_ff.cnt == LAST) begin
        nxt_state.hold = 1'b0;                       // see [R15]
      end else begin
        nxt_state.cnt = state_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_ff <= '{cnt: '0, hold: 1'b1};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign cpu_rst_out = state_ff.hold;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_warmup_full: assert property (@(posedge core_clk_in) disable iff (rst_in) // see [R15]
    $fell(state_ff.hold) |-> $past(state_ff.cnt) == LAST && !$past(hold_in))
    else $error("core released before warm-up ended");

  a_hold_while_reset: assert property (@(posedge core_clk_in) disable iff (rst_in) // see [R14]
    hold_in |=> state_ff.hold && state_ff.cnt == '0)
    else $error("core not held during reset source");

endmodule : svm_warmup

// *** rtl/svm_ctrl.sv ***
// Purpose : Supply voltage monitor control, two channels, reset release
// Assumes : Comparator and reset pins are asynchronous; low_power_in is local
// Notes   : Registers answer over Avalon-MM, one wait cycle per access
//
// Overview of operation
// [R1] Two channels, each with own enable, response and threshold select.
// [R2] Response bit 0 raises shared interrupt, 1 raises reset request.
// [R3] Disabled channel raises nothing and leaves its flags untouched.
// [R4] Enabled reset-mode channel requests reset while supply is below threshold.
// [R5] Interrupt mode pulses on crossing down, and also on crossing up.
// [R6] Sticky flag sets on detection and holds until software writes 0.
// [R7] Software writing 1 to a sticky flag does nothing.
// [R8] Detection in the same cycle as a clear leaves the flag set.
// [R9] Live status reads 1 while supply below threshold, no latching; the code reads 0 for a disabled channel.
// [R10] Channel 2 threshold field drives comparator select, resets to 10.
// [R11] Power-on and external reset return both control registers to reset.
// [R12] Top two bits of the second control register read 0.
// [R13] Software writes 0 to bits 5 and 4 of second register.
// [R14] Power-on reset holds warm-up and core; release starts warm-up.
// [R15] Core reset released only after full warm-up period.
// [R16] Other resets leave both control registers unchanged.
// [R17] Enabling while already below threshold raises configured request at once.
// [R18] Detections during low-power modes update flags only after return.
// [R19] Comparator outputs pass a two-stage synchroniser before use.
// [R20] Both channels share one single-cycle interrupt pulse per transition.
module svm_ctrl #(
  parameter int WARMUP_CYCLES = svm_pkg::WARMUP_CYCLES
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_in,
  input  wire logic [1:0]                cmp_below_in,
  input  wire logic                      por_active_in,
  input  wire logic                      ext_reset_in,
  input  wire logic                      wdt_reset_in,
  input  wire logic                      low_power_in,
  input  wire logic [svm_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  output logic      [1:0]                ch1_threshold_sel_out,
  output logic      [1:0]                ch2_threshold_sel_out,
  output logic                           low_supply_irq_out,
  output logic                           lv_reset_req_out,
  output logic                           cpu_rst_out
);

  svm_pkg::svm_state_t state_ff;
  svm_pkg::svm_state_t nxt_state;

  logic [svm_pkg::SYNC_W-1:0] sync_bits;
  logic [1:0]                 below_now;
  logic                       por_sync;
  logic                       ext_sync;
  logic                       reg_reset;
  logic                       core_hold;
  logic                       access;
  logic                       hit_ctl1;
  logic                       hit_ctl2;
  logic [7:0]                 wdata;
  logic [1:0]                 live;
  logic [1:0]                 hit;
  logic [1:0]                 irq_ev;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  svm_sync u_sync (                                  // see [R19]
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .async_in    ({ext_reset_in, por_active_in, cmp_below_in}),
    .sync_out    (sync_bits)
  );

  assign below_now = sync_bits[1:0];
  assign por_sync  = sync_bits[2];
  assign ext_sync  = sync_bits[3];

  // Only these two sources clear the control registers
  assign reg_reset = por_sync | ext_sync;            // see [R11] see [R16]

  // ----------------------------------------------------------------
  // Warm-up and core reset
  // ----------------------------------------------------------------
  // Watchdog and low-voltage resets also restart warm-up
  assign core_hold = por_sync | ext_sync | wdt_reset_in | state_ff.lvr;

  svm_warmup #(
    .WARMUP_CYCLES (WARMUP_CYCLES)
  ) u_warmup (                                       // see [R14] see [R15]
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .hold_in     (core_hold),
    .cpu_rst_out (cpu_rst_out)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign access   = (avs_read | avs_write) & state_ff.wait_req;
  assign hit_ctl1 = avs_address == svm_pkg::DETECT_FLAGS_LEVELS_ADR;
  assign hit_ctl2 = avs_address == svm_pkg::DETECT_MODE_ENABLE_ADR;
  assign wdata    = avs_writedata[7:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state            = state_ff;
    nxt_state.below_prev = state_ff.below;
    nxt_state.en_prev    = state_ff.en;
    // Comparator view frozen in low-power modes, caught up on return
    if (!low_power_in) begin
      nxt_state.below = below_now;                   // see [R18]
    end

    // Detection per channel
    live   = state_ff.en & state_ff.below;           // see [R9] see [R3]
    hit    = live;
    irq_ev = '0;
    for (int i = 0; i < 2; i++) begin
      // Fires on either edge; comparator has no hysteresis
      if (state_ff.en[i] && state_ff.mode[i] == svm_pkg::RESP_IRQ) begin // see [R2]
        if (!state_ff.en_prev[i]) begin
          irq_ev[i] = state_ff.below[i];             // see [R17]
        end else begin
          irq_ev[i] = state_ff.below[i] ^ state_ff.below_prev[i]; // see [R5]
        end
      end
    end

    // Bus access: one cycle of wait, answered the next cycle
    nxt_state.wait_req = 1'b1;
    if (access) begin
      nxt_state.wait_req = 1'b0;
      nxt_state.rdata    = '0;
      if (hit_ctl1) begin
        nxt_state.rdata[svm_pkg::CH2_FLAG_BIT]                    = state_ff.flag[1];
        nxt_state.rdata[svm_pkg::CH2_LIVE_BIT]                    = live[1];
        nxt_state.rdata[svm_pkg::CH2_LVL_LSB+:2]                  = state_ff.lvl2;
        nxt_state.rdata[svm_pkg::CH1_FLAG_BIT]                    = state_ff.flag[0];
        nxt_state.rdata[svm_pkg::CH1_LIVE_BIT]                    = live[0];
        nxt_state.rdata[svm_pkg::CH1_LVL_LSB+:2]                  = state_ff.lvl1;
        if (avs_write && avs_byteenable[0]) begin
          nxt_state.lvl2 = wdata[svm_pkg::CH2_LVL_LSB+:2];      // see [R10]
          nxt_state.lvl1 = wdata[svm_pkg::CH1_LVL_LSB+:2];      // see [R1]
          // Writing 1 keeps the flag as it is
          nxt_state.flag[1] = state_ff.flag[1] & wdata[svm_pkg::CH2_FLAG_BIT]; // see [R7]
          nxt_state.flag[0] = state_ff.flag[0] & wdata[svm_pkg::CH1_FLAG_BIT]; // see [R6]
        end
      end else if (hit_ctl2) begin
        nxt_state.rdata[svm_pkg::SPARE_LSB+:2]  = state_ff.spare; // see [R12]
        nxt_state.rdata[svm_pkg::CH2_MODE_BIT]  = state_ff.mode[1];
        nxt_state.rdata[svm_pkg::CH2_EN_BIT]    = state_ff.en[1];
        nxt_state.rdata[svm_pkg::CH1_MODE_BIT]  = state_ff.mode[0];
        nxt_state.rdata[svm_pkg::CH1_EN_BIT]    = state_ff.en[0];
        if (avs_write && avs_byteenable[0]) begin
          // Spare bits stored as written; software keeps them 0
          nxt_state.spare = wdata[svm_pkg::SPARE_LSB+:2];        // see [R13]
          nxt_state.mode  = {wdata[svm_pkg::CH2_MODE_BIT], wdata[svm_pkg::CH1_MODE_BIT]};
          nxt_state.en    = {wdata[svm_pkg::CH2_EN_BIT], wdata[svm_pkg::CH1_EN_BIT]}; // see [R1]
        end
      end
    end

    // Set applied after the clear so detection wins
    nxt_state.flag = nxt_state.flag | hit;           // see [R6] see [R8]

    // Requests
    nxt_state.lvr = |(state_ff.en & state_ff.mode & state_ff.below); // see [R4] see [R17]
    nxt_state.irq = |irq_ev;                         // see [R20]

    // Register reset from power-on or external reset only
    if (reg_reset) begin                             // see [R11]
      nxt_state.lvl1  = svm_pkg::CH1_LVL_RST;
      nxt_state.lvl2  = svm_pkg::CH2_LVL_RST;        // see [R10]
      nxt_state.spare = '0;
      nxt_state.mode  = '0;
      nxt_state.en    = '0;
      nxt_state.flag  = '0;
      nxt_state.lvr   = 1'b0;
      nxt_state.irq   = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_ff <= svm_pkg::STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata          = {24'h00_0000, state_ff.rdata};
  assign avs_waitrequest       = state_ff.wait_req;
  assign ch1_threshold_sel_out = state_ff.lvl1;
  assign ch2_threshold_sel_out = state_ff.lvl2;
  assign low_supply_irq_out    = state_ff.irq;
  assign lv_reset_req_out      = state_ff.lvr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_clear_ch1;
    access && avs_write && hit_ctl1 && avs_byteenable[0] && !wdata[svm_pkg::CH1_FLAG_BIT];
  endsequence

  sequence s_ch1_detect;
    state_ff.en[0] && state_ff.below[0] && !reg_reset;
  endsequence

  a_set_beats_clear: assert property (s_clear_ch1 and s_ch1_detect |=> state_ff.flag[0]) // see [R8]
    else $error("detection lost against clear");

  a_flag_sets_holds: assert property (s_ch1_detect ##1 // see [R6]
    (!reg_reset && !(access && avs_write && hit_ctl1))[*3] |->
    state_ff.flag[0] && $past(state_ff.flag[0], 2))
    else $error("sticky flag did not hold");

  a_no_sw_set: assert property (access && avs_write && hit_ctl2 == 1'b0 && hit_ctl1 && // see [R7]
    avs_byteenable[0] && wdata[svm_pkg::CH2_FLAG_BIT] && !state_ff.flag[1] &&
    !(state_ff.en[1] && state_ff.below[1]) |=> !state_ff.flag[1])
    else $error("software set a sticky flag");

  a_disabled_quiet: assert property (state_ff.en == 2'b00 |=> !state_ff.irq && !state_ff.lvr) // see [R3]
    else $error("disabled channel raised a request");

  a_reset_follows: assert property (state_ff.en[1] && state_ff.mode[1] && state_ff.below[1] && // see [R4]
    !reg_reset |=> lv_reset_req_out)
    else $error("reset request missing while below");

  a_enable_below: assert property ($rose(state_ff.en[0]) && !state_ff.mode[0] && // see [R17]
    state_ff.below[0] && !reg_reset |=> low_supply_irq_out)
    else $error("no request when enabled below threshold");

  a_irq_has_cause: assert property (low_supply_irq_out |-> // see [R20]
    $past(|(state_ff.en & ~state_ff.mode)))
    else $error("interrupt without enabled interrupt channel");

  a_ctl2_top_zero: assert property (access && hit_ctl2 |=> avs_readdata[7:6] == 2'b00) // see [R12]
    else $error("reserved bits read nonzero");

  a_por_restores: assert property (reg_reset |=> ch2_threshold_sel_out == 2'h2 && // see [R11]
    state_ff.en == 2'b00 && state_ff.flag == 2'b00)
    else $error("registers not restored by reset");

  a_lowpower_freeze: assert property (low_power_in ##1 low_power_in |-> // see [R18]
    state_ff.below == $past(state_ff.below))
    else $error("comparator view changed in low power");

  // ----------------------------------------------------------------
  // Request and field checks
  // ----------------------------------------------------------------
  sequence s_ch1_irq_armed;
    state_ff.en[0] && $past(state_ff.en[0]) && !state_ff.mode[0] && !reg_reset;
  endsequence

  sequence s_ch2_irq_armed;
    state_ff.en[1] && $past(state_ff.en[1]) && !state_ff.mode[1] && !reg_reset;
  endsequence

  // No hysteresis, so the upward crossing must pulse too
  a_irq_up_cross: assert property (s_ch1_irq_armed and $fell(state_ff.below[0]) |=> // see [R5]
    low_supply_irq_out)
    else $error("no interrupt on upward crossing");

  a_irq_down_cross: assert property (s_ch2_irq_armed and $rose(state_ff.below[1]) |=> // see [R5]
    low_supply_irq_out)
    else $error("no interrupt on downward crossing");

  a_irq_no_lvr: assert property (state_ff.mode == 2'b00 |=> !lv_reset_req_out) // see [R2]
    else $error("interrupt mode raised reset");

  a_lvr_holds_core: assert property (lv_reset_req_out |=> cpu_rst_out) // see [R4]
    else $error("reset request left core running");

  a_off_no_flag: assert property (!state_ff.en[1] && !state_ff.flag[1] |=> // see [R3]
    !state_ff.flag[1])
    else $error("disabled channel set its flag");

  a_ch2_flag_sets: assert property (state_ff.en[1] && state_ff.below[1] && !reg_reset |=> // see [R6]
    state_ff.flag[1])
    else $error("channel 2 flag not set");

  a_live_read: assert property (access && avs_read && hit_ctl1 |=> // see [R9]
    avs_readdata[svm_pkg::CH1_LIVE_BIT] == $past(state_ff.en[0] && state_ff.below[0]))
    else $error("live status wrong");

  a_thr_write: assert property (access && avs_write && hit_ctl1 && // see [R10]
    avs_byteenable[0] && !reg_reset |=>
    ch2_threshold_sel_out == $past(wdata[svm_pkg::CH2_LVL_LSB+:2]))
    else $error("threshold select not written");

  a_wdt_keeps: assert property (wdt_reset_in && !reg_reset && !(access && avs_write) // see [R16]
    |=> $stable(state_ff.en) && $stable(state_ff.mode) && $stable(state_ff.lvl2))
    else $error("watchdog changed control bits");

  a_sync_then_view: assert property (!low_power_in |=> // see [R19]
    state_ff.below == $past(below_now))
    else $error("view not from synchroniser");

endmodule : svm_ctrl

// *** verification/svm_supply_model.sv ***
// Purpose : Comparator pair seen by the supply monitor control
// Assumes : Supply given in millivolts, ideal comparators without delay
// Notes   : No hysteresis or chatter modelled; a noisy supply must be stepped by the bench
module svm_supply_model #(
  parameter int CH1_MV0 = 2000,
  parameter int CH1_MV1 = 2200,
  parameter int CH1_MV2 = 2400,
  parameter int CH1_MV3 = 2600
) (
  input  wire logic [15:0] supply_mv_in,
  input  wire logic [1:0]  ch1_sel_in,
  input  wire logic [1:0]  ch2_sel_in,
  output logic      [1:0]  cmp_below_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Threshold ladders
  // ----------------------------------------------------------------
  function automatic int ch1_mv(input logic [1:0] s);
    case (s)
      2'h0:    return CH1_MV0;
      2'h1:    return CH1_MV1;
      2'h2:    return CH1_MV2;
      default: return CH1_MV3;
    endcase
  endfunction : ch1_mv

  function automatic int ch2_mv(input logic [1:0] s);
    case (s)
      2'h0:    return 2350;
      2'h1:    return 3150;
      2'h2:    return 2850;
      default: return 2650;
    endcase
  endfunction : ch2_mv

  // Each code names its own level
  assign cmp_below_out[0] = (int'(supply_mv_in) < ch1_mv(ch1_sel_in));
  assign cmp_below_out[1] = (int'(supply_mv_in) < ch2_mv(ch2_sel_in));
endmodule : svm_supply_model

// *** verification/supply_voltage_monitor_ctrl_tb.sv ***
// Purpose : Self-checking bench of the supply monitor control
// Assumes : Shortened warm-up; comparator view settles within 8 cycles
// Notes   : Bits 5:4 of the second register are only ever written 0
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module supply_voltage_monitor_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          W  = 8;
  localparam logic [13:0] FL = svm_pkg::DETECT_FLAGS_LEVELS_ADR;
  localparam logic [13:0] ME = svm_pkg::DETECT_MODE_ENABLE_ADR;

  logic        core_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [1:0]  cmp_below;
  logic        por_active_in = 1'b0;
  logic        ext_reset_in = 1'b0;
  logic        wdt_reset_in = 1'b0;
  logic        low_power_in = 1'b0;
  logic [13:0] avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  ch1_sel;
  logic [1:0]  ch2_sel;
  logic        low_supply_irq_out;
  logic        lv_reset_req_out;
  logic        cpu_rst_out;
  logic [15:0] supply_mv = 16'h0ce4;
  int          n_errors = 0;
  int          compares = 0;
  int          irq_seen = 0;
  int          n;

  always #50 core_clk_in = ~core_clk_in;
  always_ff @(posedge core_clk_in) begin
    if (low_supply_irq_out === 1'b1) begin
      irq_seen <= irq_seen + 1;
    end
  end

  svm_ctrl #(.WARMUP_CYCLES(W)) u_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .cmp_below_in(cmp_below),
    .por_active_in(por_active_in), .ext_reset_in(ext_reset_in),
    .wdt_reset_in(wdt_reset_in), .low_power_in(low_power_in),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ch1_threshold_sel_out(ch1_sel),
    .ch2_threshold_sel_out(ch2_sel), .low_supply_irq_out(low_supply_irq_out),
    .lv_reset_req_out(lv_reset_req_out), .cpu_rst_out(cpu_rst_out));

  svm_supply_model u_supply (
    .supply_mv_in(supply_mv), .ch1_sel_in(ch1_sel), .ch2_sel_in(ch2_sel),
    .cmp_below_out(cmp_below));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Request stands until waitrequest is seen low at a rising edge
  task automatic bus_op(input logic wr, input logic [13:0] adr, input logic [7:0] wd,
                        output logic [7:0] rd);
    int i;
    @(posedge core_clk_in);
    avs_address   <= adr;
    avs_writedata <= {24'h0, wd};
    avs_read      <= !wr;
    avs_write     <= wr;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk_in);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 16) begin
      n_errors++;
      give_verdict();
    end
    rd = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus_op

  task automatic wr_reg(input logic [13:0] adr, input logic [7:0] wd);
    logic [7:0] dummy;
    bus_op(1'b1, adr, wd, dummy);
  endtask : wr_reg

  task automatic rd_chk(input string nm, input logic [13:0] adr, input logic [7:0] ex);
    logic [7:0] q;
    bus_op(1'b0, adr, 8'h00, q);
    `CHK(nm, ex, q)
  endtask : rd_chk

  task automatic idle(input int c);
    repeat (c) @(posedge core_clk_in);
  endtask : idle

  task automatic supply(input logic [15:0] mv);
    @(posedge core_clk_in);
    supply_mv <= mv;
    idle(8);
  endtask : supply

  // Counts cycles until the core reset drops, bounded
  task automatic wait_core(output int c);
    for (c = 0; c < 200; c++) begin
      @(negedge core_clk_in);
      if (cpu_rst_out === 1'b0) break;
    end
    if (c == 200) begin
      n_errors++;
      give_verdict();
    end
  endtask : wait_core

  task automatic pulse(input int which);
    @(posedge core_clk_in);
    if (which == 0) por_active_in <= 1'b1;
    if (which == 1) ext_reset_in <= 1'b1;
    if (which == 2) wdt_reset_in <= 1'b1;
    idle(6);
    `CHK("core_held", 1'b1, cpu_rst_out)
    por_active_in <= 1'b0;
    ext_reset_in  <= 1'b0;
    wdt_reset_in  <= 1'b0;
    wait_core(n);
    `CHK("warm_len", 1'b1, (n >= W && n <= W + 6))
  endtask : pulse

  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    idle(12);
    rst_in <= 1'b0;
    wait_core(n);
    rd_chk("fl_rst", FL, 8'h20);
    rd_chk("me_rst", ME, 8'h00);
    rd_chk("unmapped", 14'h0000, 8'h00);
    wr_reg(14'h0004, 8'hff);
    wr_reg(ME, 8'hcf);
    rd_chk("me_top", ME, 8'h0f);
    wr_reg(ME, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr_reg(FL, {2'b00, 2'(c), 2'b00, 2'(c)});
      `CHK("thr2", 2'(c), ch2_sel)
      `CHK("thr1", 2'(c), ch1_sel)
      rd_chk("thr_rd", FL, {2'b00, 2'(c), 2'b00, 2'(c)});
    end
    wr_reg(FL, 8'h20);
    supply(16'h0708);
    `CHK("off_irq", 0, irq_seen)
    rd_chk("off_fl", FL, 8'h20);
    wr_reg(ME, 8'h01);
    idle(8);
    `CHK("en_irq", 1, irq_seen)
    `CHK("irq_nolvr", 1'b0, lv_reset_req_out)
    rd_chk("det_fl", FL, 8'h2c);
    wr_reg(FL, 8'h20);
    rd_chk("set_wins", FL, 8'h2c);
    supply(16'h0ce4);
    `CHK("up_irq", 2, irq_seen)
    rd_chk("sticky", FL, 8'h28);
    wr_reg(FL, 8'h28);
    rd_chk("wr1_flag", FL, 8'h28);
    wr_reg(FL, 8'h20);
    rd_chk("clr_flag", FL, 8'h20);
    wr_reg(FL, 8'ha8);
    rd_chk("wr1_set", FL, 8'h20);
    low_power_in <= 1'b1;
    supply(16'h0708);
    `CHK("lp_irq", 2, irq_seen)
    rd_chk("lp_fl", FL, 8'h20);
    low_power_in <= 1'b0;
    idle(8);
    `CHK("lp_back", 3, irq_seen)
    rd_chk("lp_fl2", FL, 8'h2c);
    avs_byteenable <= 4'he;
    wr_reg(FL, 8'h00);
    avs_byteenable <= 4'hf;
    rd_chk("be_off", FL, 8'h2c);
    supply(16'h0ce4);
    wr_reg(FL, 8'h20);
    wr_reg(ME, 8'h0c);
    supply(16'h0708);
    `CHK("lvr_on", 1'b1, lv_reset_req_out)
    `CHK("lvr_core", 1'b1, cpu_rst_out)
    `CHK("lvr_noirq", 4, irq_seen)
    rd_chk("lvr_fl", FL, 8'he0);
    supply(16'h0ce4);
    `CHK("lvr_off", 1'b0, lv_reset_req_out)
    wait_core(n);
    rd_chk("lvr_keep", ME, 8'h0c);
    pulse(2);
    rd_chk("wdt_keep", ME, 8'h0c);
    rd_chk("wdt_keepf", FL, 8'ha0);
    pulse(0);
    rd_chk("por_me", ME, 8'h00);
    rd_chk("por_fl", FL, 8'h20);
    wr_reg(ME, 8'h05);
    wr_reg(FL, 8'h31);
    rd_chk("pre_ext", FL, 8'h31);
    pulse(1);
    rd_chk("ext_me", ME, 8'h00);
    rd_chk("ext_fl", FL, 8'h20);
    give_verdict();
  end
endmodule : supply_voltage_monitor_ctrl_tb
